// ===== hw/pdr_top.sv
// Presence-detect byte store with a two-wire serial slave port.
// Assumes SCL/SDA and the address pins come from outside the core clock,
// and that SDA is open drain with an external pull-up.
//
// Functional notes
// - After a stop that ends a write, the internal write cycle ends within 10 ms.
// - During the write cycle the port is deaf, SDA is released and nothing is acknowledged.
// - Location 0 holds the bytes-in-use count 0x80.
// - Location 1 holds the total size code 0x08.
// - Location 3 holds 0x0C rows for the two small densities and 0x0D for the largest.
// - Location 4 holds 0x0A columns for the smallest density and 0x0B for the others.
// - Location 5 reports one rank as 0x01.
// - Locations 6 and 7 hold the 72-bit data width as 0x48 and 0x00.
// - Location 8 holds the low-voltage logic level code 0x01.
// - Location 14 holds the check device width 0x04, matching location 13.
// - The banks-per-device location holds 0x04.
// - Location 22 holds the device attribute code 0x0E.
// - A start followed by our own slave address is acknowledged.
// - The select code is 1010, then the three address pins, then R/W, MSB first.
// - Reads continue while the host acknowledges and stop on a missing acknowledge.
module pdr_top
    import pdr_pkg::*;
#(
    parameter logic [1:0] DENSITY = DENS_SMALL,
    parameter logic [TIMER_W-1:0] WRITE_CYCLE_CYCLES = TIMER_W'(WRITE_CYCLE_CNT)
)
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    // Two-wire link
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // Address straps
    input wire logic [2:0] ADDRESS_PIN_IN,
    // Status
    output logic BUSY_OUT
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////
    // Types

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_RACK = 3'b100,
        ST_WAIT = 3'b101
    } pdr_link_state_type;

    typedef enum logic [1:0] {
        RX_SELECT = 2'b00,
        RX_ADDRESS = 2'b01,
        RX_DATA = 2'b10
    } pdr_rx_kind_type;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0][2:0] pin_s;
        logic scl_f;
        logic sda_f;
        logic [2:0] pin_f;
        pdr_link_state_type st;
        pdr_link_state_type after_ack;
        pdr_rx_kind_type kind;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx_sh;
        logic host_ack;
        logic [7:0] cur_addr;
        logic [7:0] fetch_addr;
        logic wrote;
        logic busy;
        logic [TIMER_W-1:0] timer;
        logic oe;
        logic sda_drv;
    } pdr_top_state_type;

    pdr_top_state_type q, d;

    // Byte store and its write port
    logic [7:0] mem [0:255];
    logic mem_we;
    logic [7:0] mem_wdata;
    logic buf_flush;

    pdr_stream_if fill_if ();
    pdr_stream_if drain_if ();

    ////////////////////////////////////////////////////////////////////
    // Default contents of each location
    function automatic logic [7:0] store_default(input logic [7:0] idx);
        logic is_large;
        logic is_small;
        logic [7:0] val;
        is_large = (DENSITY == DENS_LARGE);
        is_small = (DENSITY == DENS_SMALL);
        case (idx)
            OFS_BYTES_IN_USE: val = RST_BYTES_IN_USE;
            OFS_TOTAL_ARRAY_SIZE: val = RST_TOTAL_ARRAY_SIZE;
            OFS_MEMORY_TYPE_CODE: val = RST_MEMORY_TYPE_CODE;
            OFS_ROW_ADDRESS_BITS: val = is_large ? RST_ROWS_LARGE : RST_ROWS_SMALL;
            OFS_COLUMN_ADDRESS_BITS: val = is_small ? RST_COLS_SMALL : RST_COLS_LARGE;
            OFS_RANK_COUNT: val = RST_RANK_COUNT;
            OFS_DATA_WIDTH_LOW: val = RST_DATA_WIDTH_LOW;
            OFS_DATA_WIDTH_HIGH: val = RST_DATA_WIDTH_HIGH;
            OFS_INTERFACE_LEVEL: val = RST_INTERFACE_LEVEL;
            OFS_CYCLE_TIME_LATENCY3: val = RST_CYCLE_TIME_LATENCY3;
            OFS_ACCESS_TIME_LATENCY3: val = RST_ACCESS_TIME_LATENCY3;
            OFS_CONFIGURATION_TYPE: val = RST_CONFIGURATION_TYPE;
            OFS_REFRESH_RATE_TYPE: val = is_large ? RST_REFRESH_LARGE : RST_REFRESH_SMALL;
            OFS_PRIMARY_DEVICE_WIDTH: val = RST_PRIMARY_DEVICE_WIDTH;
            OFS_CHECK_DEVICE_WIDTH: val = RST_CHECK_DEVICE_WIDTH;
            OFS_MIN_COLUMN_DELAY: val = RST_MIN_COLUMN_DELAY;
            OFS_BURST_LENGTHS: val = RST_BURST_LENGTHS;
            OFS_BANKS_PER_DEVICE: val = RST_BANKS_PER_DEVICE;
            OFS_WRITE_LATENCY: val = RST_WRITE_LATENCY;
            OFS_MODULE_ATTRIBUTES: val = RST_MODULE_ATTRIBUTES;
            OFS_DEVICE_ATTRIBUTES: val = RST_DEVICE_ATTRIBUTES;
            OFS_CYCLE_TIME_LATENCY2: val = RST_CYCLE_TIME_LATENCY2;
            OFS_ACCESS_TIME_LATENCY2: val = RST_ACCESS_TIME_LATENCY2;
            OFS_CYCLE_TIME_LATENCY1: val = RST_LATENCY1_UNUSED;
            OFS_ACCESS_TIME_LATENCY1: val = RST_LATENCY1_UNUSED;
            default: val = RST_BLANK;
        endcase
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Read-ahead buffer between the store and the shifter

    // The shifter can only take a byte on an SCL fall, so it stalls
    // the buffer; two entries keep one byte ready without losing any.
    pdr_buf u_buf (
        .clk_in(CLOCK_IN),
        .rstn_in(RSTN_IN),
        .flush_in(buf_flush),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    // Fetch side: always offers the next location unless flushing
    assign fill_if.valid = !buf_flush;
    assign fill_if.data = mem[q.fetch_addr];

    ////////////////////////////////////////////////////////////////////
    // Link sequencing
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic take;
        logic fetched;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_seen = 1'b0;
        stop_seen = 1'b0;
        take = 1'b0;
        fetched = 1'b0;
        d = q;
        mem_we = 1'b0;
        mem_wdata = q.shreg;
        buf_flush = 1'b0;

        // Three-stage sync; a change counts once stages two and three agree
        d.scl_s = {q.scl_s[1:0], SCL_IN};
        d.sda_s = {q.sda_s[1:0], SDA_IN};
        d.pin_s = {q.pin_s[1:0], ADDRESS_PIN_IN};
        if (q.scl_s[1] == q.scl_s[2]) begin
            d.scl_f = q.scl_s[2];
        end
        if (q.sda_s[1] == q.sda_s[2]) begin
            d.sda_f = q.sda_s[2];
        end
        if (q.pin_s[1] == q.pin_s[2]) begin
            d.pin_f = q.pin_s[2];
        end

        // Edges of the filtered link levels
        scl_rise = d.scl_f && !q.scl_f;
        scl_fall = !d.scl_f && q.scl_f;
        start_seen = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
        stop_seen = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;

        // Write cycle timer; the port stays deaf until it runs out
        if (q.busy) begin
            d.timer = q.timer - TIMER_W'(1);
            if (q.timer <= TIMER_W'(1)) begin
                d.busy = 1'b0;
            end
        end

        if (stop_seen) begin
            // Stop ends any transfer and may launch the write cycle
            d.st = ST_IDLE;
            d.oe = 1'b0;
            if (q.wrote) begin
                d.wrote = 1'b0;
                d.busy = 1'b1;
                d.timer = WRITE_CYCLE_CYCLES;
            end
        end else if (start_seen && !q.busy) begin
            // Start or repeated start; ignored while busy
            d.st = ST_RX;
            d.kind = RX_SELECT;
            d.cnt = 4'h_0000;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                ST_RX: begin
                    if (scl_rise && q.cnt != BITS_PER_BYTE) begin
                        // MSB arrives first
                        d.shreg = {q.shreg[6:0], d.sda_f};
                        d.cnt = q.cnt + 4'h_0001;
                    end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                        d.cnt = 4'h_0000;
                        case (q.kind)
                            RX_SELECT: begin
                                // Only the memory array select on our pins answers
                                if (q.shreg[7:4] == SEL_MEMORY &&
                                        q.shreg[3:1] == q.pin_f) begin
                                    d.st = ST_ACK;
                                    d.oe = 1'b1;
                                    d.after_ack = q.shreg[0] ? ST_TX : ST_RX;
                                    d.kind = RX_ADDRESS;
                                end else begin
                                    d.st = ST_WAIT;
                                end
                            end
                            RX_ADDRESS: begin
                                // New byte address; read-ahead restarts there
                                d.cur_addr = q.shreg;
                                d.fetch_addr = q.shreg;
                                buf_flush = 1'b1;
                                d.st = ST_ACK;
                                d.oe = 1'b1;
                                d.after_ack = ST_RX;
                                d.kind = RX_DATA;
                            end
                            RX_DATA: begin
                                // Page write wraps within sixteen bytes
                                mem_we = 1'b1;
                                d.wrote = 1'b1;
                                d.cur_addr = {q.cur_addr[7:4], q.cur_addr[3:0] + 4'h_0001};
                                d.fetch_addr = d.cur_addr;
                                buf_flush = 1'b1;
                                d.st = ST_ACK;
                                d.oe = 1'b1;
                                d.after_ack = ST_RX;
                            end
                            default: begin
                                d.st = ST_WAIT;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Hold the acknowledge through one SCL high phase
                    if (scl_fall) begin
                        d.oe = 1'b0;
                        d.st = q.after_ack;
                        if (q.after_ack == ST_TX) begin
                            take = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        d.cnt = q.cnt + 4'h_0001;
                    end else if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            // Release SDA for the host's acknowledge
                            d.oe = 1'b0;
                            d.st = ST_RACK;
                        end else begin
                            d.tx_sh = {q.tx_sh[6:0], 1'b0};
                            d.oe = !q.tx_sh[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        d.host_ack = !d.sda_f;
                    end else if (scl_fall) begin
                        if (q.host_ack) begin
                            take = 1'b1;
                        end else begin
                            d.st = ST_WAIT;
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    d.oe = 1'b0;
                end
                default: begin
                    d.st = ST_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end

        // Load the next byte and drive its MSB on this fall
        if (take) begin
            d.tx_sh = drain_if.data;
            d.oe = !drain_if.data[7];
            d.cnt = 4'h_0000;
            d.st = ST_TX;
            d.cur_addr = q.cur_addr + 8'h_0001;
        end

        // A fetched byte moves the read-ahead pointer
        fetched = fill_if.valid && fill_if.ready;
        if (fetched && !buf_flush) begin
            d.fetch_addr = q.fetch_addr + 8'h_0001;
        end

        // Nothing drives SDA while the write cycle runs
        if (d.busy) begin
            d.oe = 1'b0;
        end
        d.sda_drv = 1'b0;
    end

    // Pop exactly when a byte is taken for shifting
    assign drain_if.ready = (q.st == ST_ACK || q.st == ST_RACK) &&
                            !d.scl_f && q.scl_f && (d.st == ST_TX);

    ////////////////////////////////////////////////////////////////////
    // State register; the SCL and SDA sync stages reset to idle-high levels
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            q <= '0;
            q.scl_s <= 3'h_0007;
            q.sda_s <= 3'h_0007;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // Byte store; reset reloads the module description
    always_ff @(posedge CLOCK_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= store_default(8'(i));
            end
        end else if (mem_we) begin
            mem[q.cur_addr] <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flops; SDA only ever pulls low
    assign SDA_OUT = q.sda_drv;
    assign SDA_OE_OUT = q.oe;
    assign BUSY_OUT = q.busy;

endmodule

// ===== hw/pdr_pkg.sv
// Constants for the presence-detect store: byte map, codes, timing.
// Assumes a 200 MHz core clock and a host-driven two-wire link.
package pdr_pkg;

    ////////////////////////////////////////////////////////////////////
    // Clock and write cycle timing
    localparam int unsigned CLOCK_MHZ = 200;
    localparam int unsigned WRITE_CYCLE_TIME_MS = 10;
    // Longest time, so it rounds down: 2,000,000 cycles
    localparam int unsigned WRITE_CYCLE_CNT = WRITE_CYCLE_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int unsigned TIMER_W = 21;

    ////////////////////////////////////////////////////////////////////
    // Link framing
    localparam logic [3:0] SEL_MEMORY = 4'h_000A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h_0008;

    ////////////////////////////////////////////////////////////////////
    // Density variants
    localparam logic [1:0] DENS_SMALL = 2'h_0000;
    localparam logic [1:0] DENS_MID = 2'h_0001;
    localparam logic [1:0] DENS_LARGE = 2'h_0002;

    ////////////////////////////////////////////////////////////////////
    // Byte offsets
    localparam logic [7:0] OFS_BYTES_IN_USE = 8'h_0000;
    localparam logic [7:0] OFS_TOTAL_ARRAY_SIZE = 8'h_0001;
    localparam logic [7:0] OFS_MEMORY_TYPE_CODE = 8'h_0002;
    localparam logic [7:0] OFS_ROW_ADDRESS_BITS = 8'h_0003;
    localparam logic [7:0] OFS_COLUMN_ADDRESS_BITS = 8'h_0004;
    localparam logic [7:0] OFS_RANK_COUNT = 8'h_0005;
    localparam logic [7:0] OFS_DATA_WIDTH_LOW = 8'h_0006;
    localparam logic [7:0] OFS_DATA_WIDTH_HIGH = 8'h_0007;
    localparam logic [7:0] OFS_INTERFACE_LEVEL = 8'h_0008;
    localparam logic [7:0] OFS_CYCLE_TIME_LATENCY3 = 8'h_0009;
    localparam logic [7:0] OFS_ACCESS_TIME_LATENCY3 = 8'h_000A;
    localparam logic [7:0] OFS_CONFIGURATION_TYPE = 8'h_000B;
    localparam logic [7:0] OFS_REFRESH_RATE_TYPE = 8'h_000C;
    localparam logic [7:0] OFS_PRIMARY_DEVICE_WIDTH = 8'h_000D;
    localparam logic [7:0] OFS_CHECK_DEVICE_WIDTH = 8'h_000E;
    localparam logic [7:0] OFS_MIN_COLUMN_DELAY = 8'h_000F;
    localparam logic [7:0] OFS_BURST_LENGTHS = 8'h_0010;
    localparam logic [7:0] OFS_BANKS_PER_DEVICE = 8'h_0011;
    localparam logic [7:0] OFS_WRITE_LATENCY = 8'h_0014;
    localparam logic [7:0] OFS_MODULE_ATTRIBUTES = 8'h_0015;
    localparam logic [7:0] OFS_DEVICE_ATTRIBUTES = 8'h_0016;
    localparam logic [7:0] OFS_CYCLE_TIME_LATENCY2 = 8'h_0017;
    localparam logic [7:0] OFS_ACCESS_TIME_LATENCY2 = 8'h_0018;
    localparam logic [7:0] OFS_CYCLE_TIME_LATENCY1 = 8'h_0019;
    localparam logic [7:0] OFS_ACCESS_TIME_LATENCY1 = 8'h_001A;

    ////////////////////////////////////////////////////////////////////
    // Reset contents
    localparam logic [7:0] RST_BYTES_IN_USE = 8'h_0080;
    localparam logic [7:0] RST_TOTAL_ARRAY_SIZE = 8'h_0008;
    localparam logic [7:0] RST_MEMORY_TYPE_CODE = 8'h_0004;
    localparam logic [7:0] RST_ROWS_SMALL = 8'h_000C;
    localparam logic [7:0] RST_ROWS_LARGE = 8'h_000D;
    localparam logic [7:0] RST_COLS_SMALL = 8'h_000A;
    localparam logic [7:0] RST_COLS_LARGE = 8'h_000B;
    localparam logic [7:0] RST_RANK_COUNT = 8'h_0001;
    localparam logic [7:0] RST_DATA_WIDTH_LOW = 8'h_0048;
    localparam logic [7:0] RST_DATA_WIDTH_HIGH = 8'h_0000;
    localparam logic [7:0] RST_INTERFACE_LEVEL = 8'h_0001;
    localparam logic [7:0] RST_CYCLE_TIME_LATENCY3 = 8'h_0075;
    localparam logic [7:0] RST_ACCESS_TIME_LATENCY3 = 8'h_0054;
    localparam logic [7:0] RST_CONFIGURATION_TYPE = 8'h_0002;
    localparam logic [7:0] RST_REFRESH_SMALL = 8'h_0080;
    localparam logic [7:0] RST_REFRESH_LARGE = 8'h_0082;
    localparam logic [7:0] RST_PRIMARY_DEVICE_WIDTH = 8'h_0004;
    localparam logic [7:0] RST_CHECK_DEVICE_WIDTH = 8'h_0004;
    localparam logic [7:0] RST_MIN_COLUMN_DELAY = 8'h_0001;
    localparam logic [7:0] RST_BURST_LENGTHS = 8'h_008F;
    localparam logic [7:0] RST_BANKS_PER_DEVICE = 8'h_0004;
    localparam logic [7:0] RST_WRITE_LATENCY = 8'h_0001;
    localparam logic [7:0] RST_MODULE_ATTRIBUTES = 8'h_001F;
    localparam logic [7:0] RST_DEVICE_ATTRIBUTES = 8'h_000E;
    localparam logic [7:0] RST_CYCLE_TIME_LATENCY2 = 8'h_00A0;
    localparam logic [7:0] RST_ACCESS_TIME_LATENCY2 = 8'h_0060;
    localparam logic [7:0] RST_LATENCY1_UNUSED = 8'h_0000;
    localparam logic [7:0] RST_BLANK = 8'h_0000;

endpackage

// ===== hw/pdr_stream_if.sv
// Byte stream with valid and ready, used around the read-ahead buffer.
// Assumes both ends sit on the same core clock.
interface pdr_stream_if;
    timeunit 1ns;
    timeprecision 100ps;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== hw/pdr_buf.sv
// Two-entry byte buffer with valid/ready on both sides and a flush.
// Assumes one core clock and a synchronous active-low reset.
module pdr_buf
    import pdr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic flush_in,
    // Streams
    pdr_stream_if.snk fill,
    pdr_stream_if.src drain
);
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [1:0][7:0] ent;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } pdr_buf_state_type;

    pdr_buf_state_type q, d;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////
    // Honest full and empty straight from the count
    assign fill.ready = (q.cnt != 2'h_0002);
    assign drain.valid = (q.cnt != 2'h_0000);
    assign drain.data = q.ent[q.rp];

    // Flush drops both entries; stale bytes never leak out
    always_comb begin
        d = q;
        push = fill.valid && fill.ready;
        pop = drain.valid && drain.ready;
        if (flush_in) begin
            d.wp = 1'b0;
            d.rp = 1'b0;
            d.cnt = 2'h_0000;
        end else begin
            if (push) begin
                d.ent[q.wp] = fill.data;
                d.wp = ~q.wp;
            end
            if (pop) begin
                d.rp = ~q.rp;
            end
            d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // Register the state copy
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// ===== tb/pdr_top_chk.sv
// Port checker for the presence-detect store.
// Assumes a bind onto pdr_top; sees only its ports.
module pdr_top_chk import pdr_pkg::*; #(
    parameter logic [TIMER_W-1:0] WRITE_CYCLE_CYCLES = TIMER_W'(WRITE_CYCLE_CNT)
) (
    // Clock, reset and link
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    // Straps and status
    input wire logic [2:0] ADDRESS_PIN_IN,
    input wire logic BUSY_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    // Busy stretch length, cleared while awake
    logic [TIMER_W-1:0] busy_cnt_q;
    always_ff @(posedge CLOCK_IN) begin
        busy_cnt_q <= (!RSTN_IN || !BUSY_OUT) ? '0 : busy_cnt_q + 1'b1;
    end
    ////////////////////////////////////////
    quiet_busy_a: assert property (BUSY_OUT |-> !SDA_OE_OUT)
        else $error("Busy but pulling");
    busy_bound_a: assert property (busy_cnt_q <= WRITE_CYCLE_CYCLES)
        else $error("Busy too long");
    busy_length_a: assert property ($fell(BUSY_OUT) |-> busy_cnt_q == WRITE_CYCLE_CYCLES)
        else $error("Busy length");
    busy_on_stop_a: assert property ($rose(BUSY_OUT) |-> SCL_IN && SDA_IN)
        else $error("Busy without stop");
    never_high_a: assert property (SDA_OUT == 1'b0)
        else $error("Data driven high");
    answer_late_a: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN, 2))
        else $error("Pull too early");
    release_low_a: assert property ($fell(SDA_OE_OUT) |-> !SCL_IN)
        else $error("Release in high");
    steady_high_a: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
        else $error("Change in high");
endmodule

// ===== tb/pdr_host_model.sv
// Two-wire host model with an 80 ns link period.
// Assumes the bench resolves SDA with a pull-up.
module pdr_host_model (
    // Core clock, wire level and host drives
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out = 1'b1,
    output logic sda_low_out = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // Wait n cycles, then set both lines
    task automatic step(input logic scl, input logic low, input int n);
        repeat (n) @(posedge clk_in);
        scl_out <= scl;
        sda_low_out <= low;
    endtask
    ////////////////////////////////////////
    // Start or repeated start
    task automatic start();
        step(1'b0, 1'b0, 4);
        step(1'b1, 1'b0, 4);
        step(1'b1, 1'b1, 8);
        step(1'b0, 1'b1, 8);
    endtask
    // Stop; clock then stands high
    task automatic stop();
        step(1'b0, 1'b1, 4);
        step(1'b1, 1'b1, 4);
        step(1'b1, 1'b0, 8);
    endtask
    // Data moves in clock low only, else it reads as start or stop
    task automatic clk_bit(input logic tx, output logic rx);
        step(1'b0, !tx, 4);
        step(1'b1, !tx, 4);
        repeat (8) @(posedge clk_in);
        rx = sda_in;
        scl_out <= 1'b0;
    endtask
    // Byte then acknowledge slot; a high slot means no acknowledge
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
        output logic nk);
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
        clk_bit(ak, nk);
    endtask
endmodule

// ===== tb/test_module_presence_detect_rom.sv
// Bench: host model reads, writes and probes the store.
// Assumes pdr_top, the host model and the checker.
module test_module_presence_detect_rom import pdr_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic oe, sda_out, busy, nak, scl, low;
    logic [2:0] pins;
    logic [7:0] rx, wa, wd, ptr;
    logic [7:0] mem [256];
    int error_cnt = 0;
    int cmp_count = 0;
    // Bytes 0 to 26 of the mid density; others zero
    localparam logic [7:0] EXP [27] = '{
        8'h80, 8'h08, 8'h04, 8'h0C, 8'h0B, 8'h01, 8'h48, 8'h00, 8'h01,
        8'h75, 8'h54, 8'h02, 8'h80, 8'h04, 8'h04, 8'h01, 8'h8F, 8'h04,
        8'h00, 8'h00, 8'h01, 8'h1F, 8'h0E, 8'hA0, 8'h60, 8'h00, 8'h00};
    wire logic sda = !(low || oe); // Open drain, pull-up
    pdr_top #(.DENSITY(DENS_MID), .WRITE_CYCLE_CYCLES(21'h_0190)) dut_u (.CLOCK_IN(clk),
        .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_OUT(oe), .ADDRESS_PIN_IN(pins), .BUSY_OUT(busy));
    pdr_host_model host_u (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(low));
    // 200 MHz core clock
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait on the busy flag
    task automatic wait_busy(input logic lvl);
        int n = 0;
        while (busy !== lvl && n < 500) begin
            @(posedge clk);
            n++;
        end
        check(8'(busy), 8'(lvl));
        if (busy !== lvl) stop_test();
    endtask
    task automatic sel(input logic [7:0] code, input logic exp_nak);
        host_u.start();
        host_u.xfer(code, 1'b1, rx, nak);
        check(8'(nak), 8'(exp_nak));
    endtask
    // Random or current read of n bytes; last byte not acknowledged
    task automatic rd(input logic [7:0] a, input int n, input logic cur);
        if (cur) begin
            a = ptr;
        end else begin
            sel({4'hA, pins, 1'b0}, 1'b0);
            host_u.xfer(a, 1'b1, rx, nak);
        end
        sel({4'hA, pins, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'hFF, i == n - 1, rx, nak);
            check(rx, mem[8'(a + i)]);
        end
        ptr = 8'(a + n);
        repeat (6) @(posedge clk);
        check(8'(oe), 8'h00);
        host_u.stop();
    endtask
    // Reads, refusals, then a write and its deaf period
    initial begin
        void'($urandom(95315));
        pins = 3'($urandom);
        foreach (mem[i]) mem[i] = (i < 27) ? EXP[i] : 8'h00;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        rd(8'h00, 27, 1'b0);
        rd(8'h00, 2, 1'b1);
        rd(8'($urandom), 3, 1'b0);
        sel({4'hA, pins ^ 3'h5, 1'b0}, 1'b1);
        host_u.stop();
        sel({4'h6, pins, 1'b1}, 1'b1);
        host_u.stop();
        wa = 8'($urandom);
        wd = 8'($urandom);
        sel({4'hA, pins, 1'b0}, 1'b0);
        host_u.xfer(wa, 1'b1, rx, nak);
        host_u.xfer(wd, 1'b1, rx, nak);
        host_u.stop();
        mem[wa] = wd;
        wait_busy(1'b1);
        sel({4'hA, pins, 1'b1}, 1'b1);
        host_u.stop();
        wait_busy(1'b0);
        rd(wa, 1, 1'b0);
        stop_test();
    end
endmodule
bind pdr_top pdr_top_chk #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) chk_u (
    .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .ADDRESS_PIN_IN(ADDRESS_PIN_IN),
    .BUSY_OUT(BUSY_OUT));
